// >>> src/perfmon_regs_pkg.sv
/*
  Package for the performance monitor interrupt message and freeze status registers.
  Assumes a 12-bit byte address into the remapping unit register space.
*/
package perfmon_regs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int REG_ADDR_W = 12;
  localparam logic [11:0] OFF_IRQ_DATA = 12'h32C;
  localparam logic [11:0] OFF_IRQ_ADDR_LO = 12'h330;
  localparam logic [11:0] OFF_IRQ_ADDR_HI = 12'h334;
  localparam logic [11:0] OFF_FRZ_BASE = 12'h340;
  localparam logic [11:0] OFF_FRZ_OFFSET = 12'h3E8;
  localparam logic [11:0] OFF_EVT_STATUS = 12'h3F0;
  localparam logic [11:0] OFF_EVT_MASK = 12'h3F4;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int PAYLOAD_W = 16;
  localparam int TARGET_LO_POS = 2;
  localparam int TARGET_LO_W = 30;
  localparam logic [15:0] IRQ_DATA_RST = 16'h0000;
  localparam logic [29:0] IRQ_ADDR_LO_RST = 30'h00000000;
  localparam logic [31:0] IRQ_ADDR_HI_RST = 32'h00000000;
  localparam int FRZ_REG_BYTES = 8;
  localparam int EVT_W = 2;
  localparam int EVT_MSG_SENT = 0;
  localparam int EVT_FRZ_CHANGE = 1;
  localparam logic [1:0] EVT_STATUS_RST = 2'h0;
  localparam logic [1:0] EVT_MASK_RST = 2'h0;

  // ****************************************
  // Command opcodes
  // ****************************************
  typedef enum logic [1:0] {
    CMD_FREEZE,
    CMD_UNFREEZE,
    CMD_DISABLE
  } cmd_op_t;

endpackage

// >>> src/perf_msg_issuer.sv
/*
  Issues the performance monitor interrupt message as one valid/ready write.
  Assumes the fabric holds msg_ready on the same clock and the mask is a register level.
*/
`timescale 1ns/100ps
`default_nettype none

module perf_msg_issuer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic perf_event,
  input wire logic perf_irq_mask,
  input wire logic pending_clear,
  input wire logic [63:0] target_addr,
  input wire logic [15:0] payload,
  input wire logic msg_ready,
  output logic msg_valid,
  output logic [63:0] msg_addr,
  output logic [31:0] msg_data,
  output logic pending
);
  import perfmon_regs_pkg::*;

  typedef struct packed {
    logic pending;
    logic valid;
    logic [63:0] addr;
    logic [31:0] data;
  } issuer_t;

  issuer_t q, d;

  // ****************************************
  // Pending and issue logic
  // ****************************************
  always_comb begin
    d = q;
    if (q.valid && msg_ready) begin
      d.valid = 1'b0;
    end
    if (pending_clear) begin
      d.pending = 1'b0;
    end
    if (q.pending && !pending_clear && !perf_irq_mask && enable &&
        (!q.valid || msg_ready)) begin
      d.valid = 1'b1;
      d.addr = target_addr;
      d.data = {16'h0000, payload};
      d.pending = 1'b0;
    end
    if (perf_event && enable) begin
      d.pending = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign msg_valid = q.valid;
  assign msg_addr = q.addr;
  assign msg_data = q.data;
  assign pending = q.pending;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_MASKED_NO_SEND: assert property ($rose(msg_valid) |-> !$past(perf_irq_mask))
    else $error("Message issued while masked.");
  AST_PEND_SENDS: assert property (pending && !perf_irq_mask && enable && !msg_valid
      && !pending_clear |=> msg_valid)
    else $error("Unmasked pending event not issued.");
  AST_MSG_HOLD: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_addr)
      && $stable(msg_data))
    else $error("Message dropped or changed before acceptance.");
  AST_MSG_ALIGN: assert property (msg_valid |-> msg_addr[1:0] == 2'h0)
    else $error("Message address not dword aligned.");

  COV_SEND: cover property (perf_event ##[1:4] msg_valid ##[1:4] msg_ready);
  COV_UNMASK: cover property (pending && perf_irq_mask ##1 !perf_irq_mask ##1 msg_valid);

endmodule

`default_nettype wire

// >>> src/perfmon_intr_msg_freeze_regs.sv
/*
  Performance monitor interrupt message registers and counter freeze status vectors.
  Assumes a single-cycle register port on ref_clk, counter logic and command engine on
  the same clock, and the supported strap arriving from a pin.
*/
// Behaviour
// - Message data is 16 writable bits; upper 16 bits read zero.
// - Lower address register keeps bits 31:2; bits 1:0 read zero.
// - With extended interrupt mode the upper address is a writable 32-bit register.
// - Without extended interrupt mode the upper address reads zero, ignores writes.
// - Without performance monitoring, data and address registers read zero, ignore writes.
// - Freeze vectors are 64-bit read-only, placed at base plus m times eight.
// - A freeze bit reads one while its counter is frozen.
// - A frozen counter stays frozen until software unfreezes it.
// - A freeze bit reads zero while its counter is not frozen.
// - Only commands and hardware freeze requests change freeze state; writes to freeze vectors do nothing.
// - A successful disable command clears that counter's freeze bit.
// - Without performance monitoring the freeze vectors are absent and read zero.
// - An unmasked event issues a message from the data and address registers.
`timescale 1ns/100ps
`default_nettype none

module perfmon_intr_msg_freeze_regs #(
  parameter int NUM_COUNTERS = 64,
  parameter bit EXT_IRQ_MODE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [perfmon_regs_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic perf_monitor_supported,
  input wire logic perf_irq_mask,
  input wire logic perf_event,
  input wire logic perf_status_clear,
  input wire logic [NUM_COUNTERS-1:0] hw_freeze_req,
  input wire logic cmd_done,
  input wire logic cmd_success,
  input wire perfmon_regs_pkg::cmd_op_t cmd_op,
  input wire logic [$clog2(NUM_COUNTERS)-1:0] cmd_idx,
  output logic [NUM_COUNTERS-1:0] counter_frozen_bits,
  output logic msg_valid,
  input wire logic msg_ready,
  output logic [63:0] msg_addr,
  output logic [31:0] msg_data,
  output logic irq_pending,
  output logic irq
);
  import perfmon_regs_pkg::*;

  // ****************************************
  // Sizes and state
  // ****************************************
  localparam int IDX_W = $clog2(NUM_COUNTERS);
  localparam int FRZ_REGS = (NUM_COUNTERS + 63) / 64;
  localparam int FRZ_PAD_W = FRZ_REGS * 64;
  localparam logic [11:0] FRZ_SPAN = 12'(FRZ_REGS * FRZ_REG_BYTES);

  typedef struct packed {
    logic [1:0] sup_sync;
    logic [15:0] payload;
    logic [29:0] target_lo;
    logic [31:0] target_hi;
    logic [NUM_COUNTERS-1:0] frozen;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_mask;
    logic [31:0] rdata;
    logic irq;
  } regs_t;

  regs_t q, d;

  logic supported;
  logic cmd_ok;
  logic msg_taken;
  logic rd_status;
  logic frz_hit;
  logic [11:0] frz_off;
  logic [FRZ_PAD_W-1:0] frz_pad;
  logic [FRZ_PAD_W-1:0] frz_shift;
  logic [EVT_W-1:0] evt_set;
  logic [63:0] target_full;

  assign supported = q.sup_sync[1];
  assign cmd_ok = cmd_done && cmd_success && supported;
  assign msg_taken = msg_valid && msg_ready;
  assign rd_status = reg_rd && (reg_addr == OFF_EVT_STATUS);
  assign frz_off = reg_addr - OFF_FRZ_BASE;
  assign frz_hit = (reg_addr >= OFF_FRZ_BASE) && (frz_off < FRZ_SPAN);
  assign frz_pad = FRZ_PAD_W'(q.frozen);
  assign frz_shift = frz_pad >> {frz_off[11:2], 5'h00};
  assign target_full = {q.target_hi, q.target_lo, 2'h0};

  always_comb begin
    evt_set = '0;
    evt_set[EVT_MSG_SENT] = msg_taken;
    evt_set[EVT_FRZ_CHANGE] = cmd_ok;
  end

  // ****************************************
  // Register writes, freeze state, read path
  // ****************************************
  always_comb begin
    d = q;
    d.sup_sync = {q.sup_sync[0], perf_monitor_supported};

    if (reg_wr && supported) begin
      if (reg_addr == OFF_IRQ_DATA) begin
        d.payload = reg_wdata[15:0];
      end else if (reg_addr == OFF_IRQ_ADDR_LO) begin
        d.target_lo = reg_wdata[31:2];
      end else if (reg_addr == OFF_IRQ_ADDR_HI) begin
        if (EXT_IRQ_MODE) begin
          d.target_hi = reg_wdata;
        end
      end
    end
    if (reg_wr && (reg_addr == OFF_EVT_MASK)) begin
      d.evt_mask = reg_wdata[EVT_W-1:0];
    end

    // Hardware freeze requests win over an unfreeze or disable command in the same cycle.
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (cmd_ok && (cmd_idx == IDX_W'(i)) &&
          ((cmd_op == CMD_UNFREEZE) || (cmd_op == CMD_DISABLE))) begin
        d.frozen[i] = 1'b0;
      end
      if (supported && (hw_freeze_req[i] ||
          (cmd_ok && (cmd_idx == IDX_W'(i)) && (cmd_op == CMD_FREEZE)))) begin
        d.frozen[i] = 1'b1;
      end
    end

    if (rd_status) begin
      d.evt_status = '0;
    end
    d.evt_status = d.evt_status | evt_set;
    d.irq = |(d.evt_status & d.evt_mask);

    if (reg_rd) begin
      d.rdata = 32'h00000000;
      if (reg_addr == OFF_EVT_STATUS) begin
        d.rdata[EVT_W-1:0] = q.evt_status;
      end else if (reg_addr == OFF_EVT_MASK) begin
        d.rdata[EVT_W-1:0] = q.evt_mask;
      end else if (!supported) begin
        d.rdata = 32'h00000000;
      end else if (reg_addr == OFF_IRQ_DATA) begin
        d.rdata[15:0] = q.payload;
      end else if (reg_addr == OFF_IRQ_ADDR_LO) begin
        d.rdata[31:2] = q.target_lo;
      end else if (reg_addr == OFF_IRQ_ADDR_HI) begin
        d.rdata = q.target_hi;
      end else if (reg_addr == OFF_FRZ_OFFSET) begin
        d.rdata[11:0] = OFF_FRZ_BASE;
      end else if (frz_hit) begin
        d.rdata = frz_shift[31:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q.sup_sync <= 2'h0;
      q.payload <= IRQ_DATA_RST;
      q.target_lo <= IRQ_ADDR_LO_RST;
      q.target_hi <= IRQ_ADDR_HI_RST;
      q.frozen <= '0;
      q.evt_status <= EVT_STATUS_RST;
      q.evt_mask <= EVT_MASK_RST;
      q.rdata <= 32'h00000000;
      q.irq <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign counter_frozen_bits = q.frozen;
  assign irq = q.irq;

  // ****************************************
  // Message issue
  // ****************************************
  perf_msg_issuer issuer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(supported),
    .perf_event(perf_event),
    .perf_irq_mask(perf_irq_mask),
    .pending_clear(perf_status_clear),
    .target_addr(target_full),
    .payload(q.payload),
    .msg_ready(msg_ready),
    .msg_valid(msg_valid),
    .msg_addr(msg_addr),
    .msg_data(msg_data),
    .pending(irq_pending)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_DATA_UPPER_ZERO: assert property (reg_rd && reg_addr == OFF_IRQ_DATA |=>
      reg_rdata[31:16] == 16'h0000)
    else $error("Message data upper half not zero.");
  AST_DATA_ROUNDTRIP: assert property (reg_wr && reg_addr == OFF_IRQ_DATA && supported
      ##1 reg_rd && reg_addr == OFF_IRQ_DATA && supported |=>
      reg_rdata[15:0] == $past(reg_wdata[15:0], 2))
    else $error("Message data did not store the written value.");
  AST_ADDR_LOW_ZERO: assert property (reg_rd && reg_addr == OFF_IRQ_ADDR_LO |=>
      reg_rdata[1:0] == 2'h0)
    else $error("Lower address bits 1:0 not zero.");
  AST_HIGH_RSVD: assert property (!EXT_IRQ_MODE && reg_rd && reg_addr == OFF_IRQ_ADDR_HI
      |=> reg_rdata == 32'h00000000)
    else $error("Upper address not reserved without extended mode.");
  AST_UNSUP_ZERO: assert property (reg_rd && !supported && (reg_addr == OFF_IRQ_DATA
      || reg_addr == OFF_IRQ_ADDR_LO || reg_addr == OFF_IRQ_ADDR_HI || frz_hit)
      |=> reg_rdata == 32'h00000000)
    else $error("Unsupported register read not zero.");
  AST_FRZ_HOLD: assert property (!cmd_ok |=>
      (counter_frozen_bits & $past(counter_frozen_bits)) == $past(counter_frozen_bits))
    else $error("Freeze bit released without a command.");
  AST_FRZ_WR_NONE: assert property (reg_wr && frz_hit && !cmd_ok && hw_freeze_req == '0
      |=> $stable(counter_frozen_bits))
    else $error("Write changed freeze state.");
  AST_DISABLE_CLR: assert property (cmd_ok && cmd_op == CMD_DISABLE &&
      !hw_freeze_req[cmd_idx] |=> !counter_frozen_bits[$past(cmd_idx)])
    else $error("Disable command did not clear freeze bit.");
  AST_MSG_TARGET: assert property ($rose(msg_valid) |->
      msg_addr == $past(target_full) && msg_data[15:0] == $past(q.payload))
    else $error("Message target or payload wrong.");

  COV_FREEZE_READ: cover property (cmd_ok && cmd_op == CMD_FREEZE ##1 reg_rd && frz_hit);
  COV_IRQ: cover property (msg_taken ##[1:3] irq ##[1:4] rd_status);
  COV_DISABLE: cover property (counter_frozen_bits != '0 ##1 cmd_ok && cmd_op == CMD_DISABLE);

endmodule

`default_nettype wire

// >>> sim/irq_fabric_model.sv
/*
  Fabric model that accepts interrupt message writes after a programmable stall.
  Assumes msg_valid holds address and data stable until the accepting edge.
*/
`timescale 1ns/100ps
`default_nettype none

module irq_fabric_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic msg_valid,
  input wire logic [63:0] msg_addr,
  input wire logic [31:0] msg_data,
  input wire logic [3:0] stall,
  output logic msg_ready,
  output logic [63:0] last_addr,
  output logic [31:0] last_data,
  output logic [7:0] count
);
  logic [3:0] wait_cnt;

  // ****************************************
  // Accept after stall cycles
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      msg_ready <= 1'b0;
      wait_cnt <= 4'h0;
      count <= 8'h00;
      last_addr <= 64'h0;
      last_data <= 32'h0;
    end else if (msg_valid && msg_ready) begin
      msg_ready <= 1'b0;
      wait_cnt <= 4'h0;
      last_addr <= msg_addr;
      last_data <= msg_data;
      count <= count + 8'h01;
    end else if (msg_valid) begin
      if (wait_cnt >= stall) begin
        msg_ready <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

// >>> sim/tb_perfmon_intr_msg_freeze_regs.sv
/*
  Testbench for the interrupt message and freeze status registers.
  Assumes the fabric model and the design on one 200 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_perfmon_intr_msg_freeze_regs;
  import perfmon_regs_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sup = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, msg_data, last_data;
  logic mask = 1'b0, ev = 1'b0, sclr = 1'b0, done = 1'b0, ok = 1'b0;
  logic [63:0] hfrz = 64'h0, frz, msg_addr, last_addr;
  cmd_op_t op = CMD_FREEZE;
  logic [5:0] idx = 6'h00;
  logic msg_valid, msg_ready, irq_pending, irq;
  logic [7:0] count;
  int fail_count = 0, comparisons = 0;

  perfmon_intr_msg_freeze_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .perf_monitor_supported(sup), .perf_irq_mask(mask), .perf_event(ev),
    .perf_status_clear(sclr), .hw_freeze_req(hfrz), .cmd_done(done), .cmd_success(ok),
    .cmd_op(op), .cmd_idx(idx), .counter_frozen_bits(frz), .msg_valid(msg_valid),
    .msg_ready(msg_ready), .msg_addr(msg_addr), .msg_data(msg_data),
    .irq_pending(irq_pending), .irq(irq));
  irq_fabric_model fab (.ref_clk(ref_clk), .rst_n(rst_n), .msg_valid(msg_valid),
    .msg_addr(msg_addr), .msg_data(msg_data), .stall(4'h2), .msg_ready(msg_ready),
    .last_addr(last_addr), .last_data(last_data), .count(count));

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(string name, logic [11:0] a, logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(name, {32'h0, exp}, {32'h0, reg_rdata});
  endtask

  task automatic pulse_event();
    @(posedge ref_clk);
    ev <= 1'b1;
    @(posedge ref_clk);
    ev <= 1'b0;
  endtask

  task automatic cmd(cmd_op_t o, logic [5:0] i, logic s);
    @(posedge ref_clk);
    done <= 1'b1;
    ok <= s;
    op <= o;
    idx <= i;
    @(posedge ref_clk);
    done <= 1'b0;
    #1;
  endtask

  task automatic wait_msgs(logic [7:0] n);
    int k;
    for (k = 0; k < 40 && count !== n; k++) @(posedge ref_clk);
    if (count !== n) begin
      $display("CHECK FAILED message count expected %h seen %h", n, count);
      fail_count++;
      summarize();
    end
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rd("data reset", OFF_IRQ_DATA, 32'h0);
    rd("addr high reset", OFF_IRQ_ADDR_HI, 32'h0);
    wr(OFF_IRQ_DATA, 32'hFFFFFFFF);
    rd("data field", OFF_IRQ_DATA, 32'h0000FFFF);
    wr(OFF_IRQ_ADDR_LO, 32'hFFFFFFFF);
    rd("addr low field", OFF_IRQ_ADDR_LO, 32'hFFFFFFFC);
    wr(OFF_IRQ_ADDR_HI, 32'hA5A5F00F);
    rd("addr high field", OFF_IRQ_ADDR_HI, 32'hA5A5F00F);
    rd("unmapped", 12'h100, 32'h0);
    $display("Test registers done");
  endtask

  task automatic t_msg();
    int k;
    wr(OFF_IRQ_DATA, 32'h00001234);
    wr(OFF_IRQ_ADDR_LO, 32'hCAFE0010);
    wr(OFF_IRQ_ADDR_HI, 32'h00000001);
    wr(OFF_EVT_MASK, 32'h00000001);
    pulse_event();
    wait_msgs(8'h01);
    chk("message addr", 64'h00000001CAFE0010, last_addr);
    chk("message data", 64'h00001234, {32'h0, last_data});
    chk("irq after send", 64'h1, {63'h0, irq});
    rd("event status", OFF_EVT_STATUS, 32'h00000001);
    @(posedge ref_clk);
    #1 chk("irq after status read", 64'h0, {63'h0, irq});
    @(posedge ref_clk);
    mask <= 1'b1;
    pulse_event();
    for (k = 0; k < 6; k++) @(posedge ref_clk);
    #1 chk("masked valid", 64'h0, {63'h0, msg_valid});
    chk("masked pending", 64'h1, {63'h0, irq_pending});
    @(posedge ref_clk);
    sclr <= 1'b1;
    @(posedge ref_clk);
    sclr <= 1'b0;
    #1 chk("cleared pending", 64'h0, {63'h0, irq_pending});
    @(posedge ref_clk);
    mask <= 1'b0;
    for (k = 0; k < 6; k++) @(posedge ref_clk);
    #1 chk("no message after clear", 64'h1, {56'h0, count});
    @(posedge ref_clk);
    mask <= 1'b1;
    pulse_event();
    @(posedge ref_clk);
    mask <= 1'b0;
    wait_msgs(8'h02);
    chk("released addr", 64'h00000001CAFE0010, last_addr);
    rd("status clears", OFF_EVT_STATUS, 32'h00000001);
    $display("Test message done");
  endtask

  task automatic t_frz();
    int k;
    @(posedge ref_clk);
    hfrz <= 64'h20;
    @(posedge ref_clk);
    hfrz <= 64'h0;
    rd("freeze low word", OFF_FRZ_BASE, 32'h00000020);
    wr(OFF_FRZ_BASE, 32'h00000000);
    for (k = 0; k < 20; k++) @(posedge ref_clk);
    rd("freeze after write", OFF_FRZ_BASE, 32'h00000020);
    cmd(CMD_DISABLE, 6'd5, 1'b0);
    chk("failed disable", 64'h20, frz);
    cmd(CMD_FREEZE, 6'd40, 1'b1);
    rd("freeze high word", OFF_FRZ_BASE + 12'h004, 32'h00000100);
    cmd(CMD_UNFREEZE, 6'd40, 1'b1);
    chk("unfreeze", 64'h20, frz);
    cmd(CMD_DISABLE, 6'd5, 1'b1);
    chk("disable clears", 64'h0, frz);
    rd("freeze offset", OFF_FRZ_OFFSET, {20'h0, OFF_FRZ_BASE});
    rd("command event status", OFF_EVT_STATUS, 32'h00000002);
    $display("Test freeze done");
  endtask

  task automatic t_unsup();
    int k;
    @(posedge ref_clk);
    sup <= 1'b0;
    for (k = 0; k < 4; k++) @(posedge ref_clk);
    rd("unsupported data", OFF_IRQ_DATA, 32'h0);
    wr(OFF_IRQ_ADDR_LO, 32'h12345678);
    rd("unsupported addr", OFF_IRQ_ADDR_LO, 32'h0);
    cmd(CMD_FREEZE, 6'd1, 1'b1);
    chk("unsupported freeze state", 64'h0, frz);
    rd("unsupported freeze", OFF_FRZ_BASE, 32'h0);
    @(posedge ref_clk);
    sup <= 1'b1;
    for (k = 0; k < 4; k++) @(posedge ref_clk);
    rd("write ignored", OFF_IRQ_ADDR_LO, 32'hCAFE0010);
    $display("Test unsupported done");
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_regs();
    t_msg();
    t_frz();
    t_unsup();
    summarize();
  end
endmodule

`default_nettype wire
